// File: bstfo_flag_update.sv
`timescale 1ns/1ps
module bstfo_flag_update
    import bstfo_pkg::*;
(
    input  wire logic [NFLAG-1:0]   flags_cur,
    input  wire logic [PARAM_W-1:0] param,
    output wire logic [NFLAG-1:0]   flags_new
);

    genvar n;
    generate
        for (n = 0; n < NFLAG; n++) begin : g_flag
            wire logic [1:0] act;
            assign act = {param[n+NFLAG], param[n]};
            assign flags_new[n] = (act == FACT_SET)    ? 1'b1 :
                                  (act == FACT_CLEAR)  ? 1'b0 :
                                  (act == FACT_TOGGLE) ? ~flags_cur[n] :
                                                         flags_cur[n];
        end
    endgenerate

endmodule

// File: bstfo_pkg.sv
package bstfo_pkg;

    // opcodes handled here
    localparam logic [15:0] EXECUTE_MESSAGE_OP      = 16'h0001;
    localparam logic [15:0] WAIT_FRAME_ZERO_OP      = 16'h0009;
    localparam logic [15:0] COMPARE_FRAME_OP        = 16'h000A;
    localparam logic [15:0] COMPARE_MESSAGE_TIME_OP = 16'h000B;
    localparam logic [15:0] GENERAL_FLAG_UPDATE_OP  = 16'h000C;

    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 8;
    localparam int PARAM_W = 16;
    localparam int CNT_W   = 16;
    localparam int NFLAG   = 8;
    localparam int COND_W  = 5;

    // counter scaling, microseconds per count; counters arrive pre-scaled
    localparam int FRAME_LSB_US = 100;
    localparam int MSG_LSB_US   = 1;

    // register byte offsets
    localparam logic [7:0] REG_FLAGS  = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CTRL   = 8'h08;
    localparam logic [7:0] REG_SNAP   = 8'h0C;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_WAIT_BIT = 0;
    localparam int ST_LT_BIT   = 1;
    localparam int ST_EQ_BIT   = 2;
    localparam int ST_REJ_BIT  = 3;
    localparam int FLAG_LT_BIT = 0;
    localparam int FLAG_EQ_BIT = 1;

    // reset values
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic        CTRL_RST  = 1'b1;
    localparam logic [15:0] SNAP_RST  = 16'h0000;

    // condition codes; everything above COND_NE is barred for execute
    localparam logic [4:0] COND_ALWAYS  = 5'h00;
    localparam logic [4:0] COND_NEVER   = 5'h01;
    localparam logic [4:0] COND_GENERAL_FLAG_0 = 5'h02;
    localparam logic [4:0] COND_GENERAL_FLAG_7 = 5'h09;
    localparam logic [4:0] COND_LT      = 5'h0A;
    localparam logic [4:0] COND_GE      = 5'h0B;
    localparam logic [4:0] COND_EQ      = 5'h0C;
    localparam logic [4:0] COND_NE      = 5'h0D;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // flag action codes, {high bit, low bit}
    localparam logic [1:0] FACT_KEEP   = 2'h0;
    localparam logic [1:0] FACT_SET    = 2'h1;
    localparam logic [1:0] FACT_CLEAR  = 2'h2;
    localparam logic [1:0] FACT_TOGGLE = 2'h3;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } bstfo_state_type;

endpackage

// File: bstfo_seq_model.sv
`timescale 1ns/1ps
module bstfo_seq_model
    import bstfo_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               nrst,
    input  wire logic               go,
    input  wire logic               allow_bad,
    input  wire logic [15:0]        op,
    input  wire logic [PARAM_W-1:0] prm,
    input  wire logic [COND_W-1:0]  cc,
    input  wire logic [NFLAG-1:0]   flags,
    input  wire logic               ready,
    output logic                    valid,
    output logic      [15:0]        opcode,
    output logic      [PARAM_W-1:0] param,
    output logic      [COND_W-1:0]  code,
    output logic                    cond_true,
    output logic                    done
);
    wire logic [4:0] gi = code - COND_GENERAL_FLAG_0;
    wire logic       is_gp = (code >= COND_GENERAL_FLAG_0)
                             && (code <= COND_GENERAL_FLAG_7);
    // legal condition sources
    // barred codes report true so a wrongful grant would show
    always_comb begin
        case (code)
            COND_ALWAYS: cond_true = 1'b1;
            COND_NEVER:  cond_true = 1'b0;
            COND_LT:     cond_true = flags[FLAG_LT_BIT];
            COND_GE:     cond_true = ~flags[FLAG_LT_BIT];
            COND_EQ:     cond_true = flags[FLAG_EQ_BIT];
            COND_NE:     cond_true = ~flags[FLAG_EQ_BIT];
            default:     cond_true = is_gp ? flags[gi[2:0]] : 1'b1;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            valid  <= 1'b0;
            done   <= 1'b0;
            opcode <= 16'h0000;
            param  <= 16'h0000;
            code   <= 5'h00;
        end else begin
            done <= 1'b0;
            if (go) begin
                valid  <= 1'b1;
                opcode <= op;
                param  <= prm;
                code   <= (cc > COND_NE && !allow_bad) ? COND_NEVER : cc;
            end else if (valid && ready) begin
                valid <= 1'b0;
                done  <= 1'b1;
            end
        end
    end
endmodule

// File: bstfo_seq_ops.sv
`timescale 1ns/1ps
module bstfo_seq_ops
    import bstfo_pkg::*;
(
    input  wire logic               MCLK,
    input  wire logic               NRST,
    input  wire logic [ADDR_W-1:0]  S_AXI_AWADDR,
    input  wire logic               S_AXI_AWVALID,
    output wire logic               S_AXI_AWREADY,
    input  wire logic [DATA_W-1:0]  S_AXI_WDATA,
    input  wire logic [3:0]         S_AXI_WSTRB,
    input  wire logic               S_AXI_WVALID,
    output wire logic               S_AXI_WREADY,
    output logic      [1:0]         S_AXI_BRESP,
    output logic                    S_AXI_BVALID,
    input  wire logic               S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0]  S_AXI_ARADDR,
    input  wire logic               S_AXI_ARVALID,
    output wire logic               S_AXI_ARREADY,
    output logic      [DATA_W-1:0]  S_AXI_RDATA,
    output logic      [1:0]         S_AXI_RRESP,
    output logic                    S_AXI_RVALID,
    input  wire logic               S_AXI_RREADY,
    input  wire logic               INSTR_VALID,
    output wire logic               INSTR_READY,
    input  wire logic [15:0]        INSTR_OPCODE,
    input  wire logic [PARAM_W-1:0] INSTR_PARAM,
    input  wire logic               INSTR_COND_TRUE,
    input  wire logic [COND_W-1:0]  INSTR_COND_CODE,
    input  wire logic [CNT_W-1:0]   FRAME_COUNT,
    input  wire logic [CNT_W-1:0]   MSG_COUNT,
    output logic                    NEXT_OP,
    output logic                    EXEC_GRANT,
    output logic                    EXEC_REJECT,
    output wire logic [NFLAG-1:0]   GP_FLAGS
);

    bstfo_state_type  state_q;
    bstfo_state_type  state_d;
    logic [NFLAG-1:0] flags_q;
    logic [NFLAG-1:0] flags_d;
    logic             en_q;
    logic             rej_q;
    logic             last_lt_q;
    logic             last_eq_q;
    logic [CNT_W-1:0] snap_q;
    logic             aw_hold_q;
    logic             w_hold_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [DATA_W-1:0] w_data_q;
    logic [3:0]       w_strb_q;

    // instruction decode
    wire logic is_wait_frame;
    wire logic is_cmp_frame;
    wire logic is_cmp_msg;
    wire logic is_flag_upd;
    wire logic is_execute;
    wire logic is_ours;
    wire logic accept;
    wire logic frame_zero;

    assign is_wait_frame = INSTR_OPCODE == WAIT_FRAME_ZERO_OP;
    assign is_cmp_frame  = INSTR_OPCODE == COMPARE_FRAME_OP;
    assign is_cmp_msg    = INSTR_OPCODE == COMPARE_MESSAGE_TIME_OP;
    assign is_flag_upd   = INSTR_OPCODE == GENERAL_FLAG_UPDATE_OP;
    assign is_execute    = INSTR_OPCODE == EXECUTE_MESSAGE_OP;
    assign is_ours       = is_wait_frame | is_cmp_frame | is_cmp_msg
                         | is_flag_upd | is_execute;
    assign frame_zero    = FRAME_COUNT == '0;

    // other opcodes belong to other units and are never taken here
    assign INSTR_READY = (state_q == ST_IDLE) && en_q && is_ours;
    assign accept      = INSTR_VALID && INSTR_READY;

    // timer compares
    wire logic [CNT_W-1:0] cmp_count;
    wire logic             cmp_lt;
    wire logic             cmp_eq;
    wire logic [NFLAG-1:0] cmp_flags;
    wire logic [NFLAG-1:0] upd_flags;

    assign cmp_count = is_cmp_msg ? MSG_COUNT : FRAME_COUNT;
    assign cmp_lt    = INSTR_PARAM < cmp_count;
    assign cmp_eq    = INSTR_PARAM == cmp_count;
    // flag 0 is lt, flag 1 is eq
    assign cmp_flags = {flags_q[NFLAG-1:2], cmp_eq, cmp_lt};

    bstfo_flag_update bstfo_flag_update_inst (
        .flags_cur (flags_q),
        .param     (INSTR_PARAM),
        .flags_new (upd_flags)
    );

    // flag storage
    wire logic seq_cmp;
    wire logic seq_flag_upd;
    wire logic host_flag_wr;
    wire logic wr_fire;
    wire logic [7:0] wr_addr;

    assign seq_cmp = accept && (is_cmp_frame || is_cmp_msg);
    assign seq_flag_upd = accept && is_flag_upd;
    assign wr_fire = aw_hold_q && w_hold_q && !S_AXI_BVALID;
    assign wr_addr = {aw_addr_q[7:2], 2'b00};
    assign host_flag_wr = wr_fire && (wr_addr == REG_FLAGS) && w_strb_q[0];

    // sequencer update wins over a host write in the same cycle
    // only compare, flag op or host write
    assign flags_d = seq_cmp      ? cmp_flags :
                     seq_flag_upd ? upd_flags :
                     host_flag_wr ? w_data_q[NFLAG-1:0] :
                                    flags_q;
    assign GP_FLAGS = flags_q;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // wait and advance
    wire logic wait_stall;
    wire logic wait_done;
    wire logic next_d;

    assign wait_stall = accept && is_wait_frame && INSTR_COND_TRUE
                        && !frame_zero;
    assign wait_done = (state_q == ST_WAIT) && frame_zero;
    assign next_d = (accept && (is_cmp_frame || is_cmp_msg || is_flag_upd))
                  || (accept && is_wait_frame && !wait_stall)
                  || wait_done;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (wait_stall) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (frame_zero) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // execute gating
    wire logic exec_legal;
    wire logic exec_take;

    // always, never, flags, compare flags only
    assign exec_legal = INSTR_COND_CODE <= COND_NE;
    assign exec_take  = accept && is_execute;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            state_q     <= ST_IDLE;
            NEXT_OP     <= 1'b0;
            EXEC_GRANT  <= 1'b0;
            EXEC_REJECT <= 1'b0;
        end else begin
            state_q     <= state_d;
            NEXT_OP     <= next_d;
            EXEC_GRANT  <= exec_take && exec_legal && INSTR_COND_TRUE;
            EXEC_REJECT <= exec_take && !exec_legal;
        end
    end

    // status capture
    wire logic rej_clr;

    assign rej_clr = wr_fire && (wr_addr == REG_STATUS) && w_strb_q[0]
                     && w_data_q[ST_REJ_BIT];

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            rej_q     <= 1'b0;
            last_lt_q <= 1'b0;
            last_eq_q <= 1'b0;
            snap_q    <= SNAP_RST;
        end else begin
            // a new reject wins over the clear
            rej_q <= (exec_take && !exec_legal) || (rej_q && !rej_clr);
            if (seq_cmp) begin
                last_lt_q <= cmp_lt;
                last_eq_q <= cmp_eq;
                snap_q    <= cmp_count;
            end
        end
    end

    // register bus write
    assign S_AXI_AWREADY = !aw_hold_q;
    assign S_AXI_WREADY  = !w_hold_q;

    wire logic wr_mapped;

    assign wr_mapped = (wr_addr == REG_FLAGS) || (wr_addr == REG_STATUS)
                     || (wr_addr == REG_CTRL) || (wr_addr == REG_SNAP);

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            aw_addr_q    <= '0;
            w_data_q     <= '0;
            w_strb_q     <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
            en_q         <= CTRL_RST;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                w_data_q <= S_AXI_WDATA;
                w_strb_q <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (wr_fire && (wr_addr == REG_CTRL) && w_strb_q[0]) begin
                en_q <= w_data_q[CTRL_EN_BIT];
            end
        end
    end

    // register bus read
    wire logic [7:0]        rd_addr;
    wire logic [DATA_W-1:0] status_word;
    wire logic [DATA_W-1:0] rd_word;
    wire logic              rd_mapped;

    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_addr = {S_AXI_ARADDR[7:2], 2'b00};
    assign status_word = {28'h0000000, rej_q, last_eq_q, last_lt_q,
                          state_q == ST_WAIT};
    assign rd_mapped = (rd_addr == REG_FLAGS) || (rd_addr == REG_STATUS)
                     || (rd_addr == REG_CTRL) || (rd_addr == REG_SNAP);
    assign rd_word =
        (rd_addr == REG_FLAGS)  ? {24'h000000, flags_q} :
        (rd_addr == REG_STATUS) ? status_word :
        (rd_addr == REG_CTRL)   ? {31'h00000000, en_q} :
        (rd_addr == REG_SNAP)   ? {16'h0000, snap_q} :
                                  32'h00000000;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= '0;
            S_AXI_RRESP  <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_word;
            S_AXI_RRESP  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    AST_WAIT_SKIP: assert property (
        accept && is_wait_frame && !INSTR_COND_TRUE |=> NEXT_OP
    ) else $error("skipped wait did not advance");

    AST_WAIT_HOLD: assert property (
        state_q == ST_WAIT && !frame_zero |=> !NEXT_OP && !INSTR_READY
    ) else $error("wait released before frame zero");

    // a second pulse is only legal for a freshly taken instruction
    AST_WAIT_DONE: assert property (
        state_q == ST_WAIT && frame_zero
        |=> NEXT_OP ##1 (!NEXT_OP || $past(accept))
    ) else $error("wait end did not advance once");

    AST_CMP_LT: assert property (
        seq_cmp && cmp_lt |=> flags_q[FLAG_LT_BIT] && !flags_q[FLAG_EQ_BIT]
    ) else $error("below outcome flags wrong");

    AST_CMP_EQ: assert property (
        seq_cmp && cmp_eq |=> !flags_q[FLAG_LT_BIT] && flags_q[FLAG_EQ_BIT]
    ) else $error("equal outcome flags wrong");

    AST_CMP_GT: assert property (
        seq_cmp && INSTR_PARAM > cmp_count
        |=> flags_q[1:0] == 2'h0 && NEXT_OP
    ) else $error("above outcome flags wrong");

    AST_MSG_CMP_SRC: assert property (
        accept && is_cmp_msg |=> snap_q == $past(MSG_COUNT)
                             && last_lt_q == ($past(INSTR_PARAM)
                                              < $past(MSG_COUNT))
    ) else $error("message compare used wrong counter");

    AST_CMP_KEEP: assert property (
        seq_cmp |=> flags_q[NFLAG-1:2] == $past(flags_q[NFLAG-1:2])
    ) else $error("compare touched general flags");

    AST_FLAGS_STILL: assert property (
        !seq_cmp && !seq_flag_upd && !host_flag_wr |=> $stable(flags_q)
    ) else $error("flags changed without cause");

    AST_FLAG_SET1: assert property (
        seq_flag_upd && !INSTR_PARAM[9] && INSTR_PARAM[1] |=> flags_q[1]
    ) else $error("set action on flag 1 missed");

    AST_FLAG_TGL0: assert property (
        seq_flag_upd && INSTR_PARAM[8] && INSTR_PARAM[0]
        |=> flags_q[0] != $past(flags_q[0])
    ) else $error("toggle action on flag 0 missed");

    AST_EXEC_GATE: assert property (
        exec_take && INSTR_COND_CODE > COND_NE
        |=> EXEC_REJECT && !EXEC_GRANT && rej_q
    ) else $error("barred execute condition passed");

    COV_WAIT_FRAME: cover property (wait_stall ##[1:20] wait_done);
    COV_FRAME_EQ:   cover property (accept && is_cmp_frame && cmp_eq);
    COV_FLAG_TGL:   cover property (seq_flag_upd && INSTR_PARAM[15:8] == 8'hFF);
    COV_EXEC_REJ:   cover property (EXEC_REJECT);

endmodule

// File: tb_bc_sequencer_timer_flag_ops.sv
`timescale 1ns/1ps
module tb_bc_sequencer_timer_flag_ops;
    import bstfo_pkg::*;
    localparam logic [15:0] OP_WAIT  = WAIT_FRAME_ZERO_OP;
    localparam logic [15:0] OP_CMPF  = COMPARE_FRAME_OP;
    localparam logic [15:0] OP_CMPM  = COMPARE_MESSAGE_TIME_OP;
    localparam logic [15:0] OP_FLAGS = GENERAL_FLAG_UPDATE_OP;
    localparam logic [15:0] OP_EXEC  = EXECUTE_MESSAGE_OP;
    logic        mclk = 1'b0, nrst = 1'b0, go = 1'b0, bad = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [15:0] op = 16'h0, prm = 16'h0, frame = 16'h0, msg = 16'h0;
    logic [4:0]  cc = 5'h00;
    wire logic   awready, wready, bvalid, arready, rvalid, ivalid, iready;
    wire logic   itrue, next_op, grant, rej, done;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] iop, iprm;
    wire logic [4:0]  icode;
    wire logic [7:0]  gp;
    int err_count = 0, n_tests = 0, n_next = 0, n_grant = 0, n_rej = 0;
    logic [15:0] t_op[6] = '{OP_CMPF, OP_CMPF, OP_CMPF,
                             OP_CMPM, OP_CMPM, OP_CMPM};
    logic [15:0] t_p[6] = '{16'h5, 16'h7, 16'hFFFF, 16'h3, 16'h9, 16'h8000};
    logic [15:0] t_f[6] = '{16'h7, 16'h7, 16'h1, 16'h3, 16'h0, 16'h8000};
    logic [15:0] t_m[6] = '{16'h5, 16'h0, 16'hFFFF, 16'h9, 16'h9, 16'h7FFF};
    logic [1:0]  t_e[6] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0};
    logic [15:0] f_p[4] = '{16'h00A5, 16'hFF0F, 16'h0F30, 16'h0000};
    logic [7:0]  f_e[4] = '{8'hA5, 8'h0A, 8'h30, 8'h30};

    bstfo_seq_ops bstfo_seq_ops_inst (
        .MCLK(mclk), .NRST(nrst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .INSTR_VALID(ivalid), .INSTR_READY(iready), .INSTR_OPCODE(iop),
        .INSTR_PARAM(iprm), .INSTR_COND_TRUE(itrue),
        .INSTR_COND_CODE(icode), .FRAME_COUNT(frame), .MSG_COUNT(msg),
        .NEXT_OP(next_op), .EXEC_GRANT(grant), .EXEC_REJECT(rej),
        .GP_FLAGS(gp)
    );
    bstfo_seq_model bstfo_seq_model_inst (
        .mclk(mclk), .nrst(nrst), .go(go), .allow_bad(bad), .op(op),
        .prm(prm), .cc(cc), .flags(gp), .ready(iready), .valid(ivalid),
        .opcode(iop), .param(iprm), .code(icode), .cond_true(itrue),
        .done(done)
    );

    initial begin
        forever #20 mclk = ~mclk;
    end
    // pulse tallies; pulses last one cycle
    always @(posedge mclk) begin
        n_next  += int'(next_op === 1'b1);
        n_grant += int'(grant === 1'b1);
        n_rej   += int'(rej === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ready and valid are read at the edge, before that edge's updates
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int k;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        if (k == 40)
            chk(32'h0, 32'h1, "write timeout");
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
        // one idle edge so the next request never re-drives bready now
        @(posedge mclk);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        int k;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        if (k == 40)
            chk(32'h0, 32'h1, "read timeout");
        chk(rdata, ed, "rdata");
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
        @(posedge mclk);
    endtask
    task automatic run_op(input logic [15:0] o, input logic [15:0] p,
                          input logic [4:0] c, input int en, input int eg,
                          input int ej);
        int k;
        int b0;
        int b1;
        int b2;
        b0 = n_next;
        b1 = n_grant;
        b2 = n_rej;
        op  <= o;
        prm <= p;
        cc  <= c;
        go  <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++)
            @(posedge mclk);
        if (k == 40)
            chk(32'h0, 32'h1, "op timeout");
        repeat (3) @(posedge mclk);
        chk(n_next - b0, en, "next op");
        chk(n_grant - b1, eg, "grant");
        chk(n_rej - b2, ej, "reject");
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        end_of_test();
    end

    initial begin
        int i;
        int g;
        int ej;
        logic [7:0] f;
        logic [31:0] e;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        chk({24'h0, gp}, {24'h0, FLAGS_RST}, "flags reset");
        axi_rd(REG_FLAGS, 32'h0, RESP_OKAY);
        axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
        axi_rd(REG_CTRL, {31'h0, CTRL_RST}, RESP_OKAY);
        axi_rd(REG_SNAP, {16'h0, SNAP_RST}, RESP_OKAY);
        axi_rd(8'h10, 32'h0, RESP_SLVERR);
        axi_wr(8'h14, 32'hFF, RESP_SLVERR);
        $display("test reset done");
        axi_wr(REG_FLAGS, 32'hA4, RESP_OKAY);
        for (i = 0; i < 6; i++) begin
            frame <= t_f[i];
            msg   <= t_m[i];
            run_op(t_op[i], t_p[i], COND_NEVER, 1, 0, 0);
            e = {24'h0, 6'h29, t_e[i]};
            chk({24'h0, gp}, e, "cmp");
            e = (t_op[i] == OP_CMPF) ? {16'h0, t_f[i]} : {16'h0, t_m[i]};
            axi_rd(REG_SNAP, e, RESP_OKAY);
        end
        $display("test compare done");
        for (i = 0; i < 4; i++) begin
            run_op(OP_FLAGS, f_p[i], COND_NEVER, 1, 0, 0);
            chk({24'h0, gp}, {24'h0, f_e[i]}, "flag op");
        end
        axi_rd(REG_FLAGS, 32'h30, RESP_OKAY);
        $display("test flag done");
        frame <= 16'h0005;
        run_op(OP_WAIT, 16'h0, COND_NEVER, 1, 0, 0);
        frame <= 16'h0000;
        run_op(OP_WAIT, 16'h0, COND_ALWAYS, 1, 0, 0);
        frame <= 16'h0005;
        run_op(OP_WAIT, 16'h0, 5'h06, 0, 0, 0);
        chk({31'h0, iready}, 32'h0, "stall ready");
        axi_rd(REG_STATUS, 32'h1, RESP_OKAY);
        i = n_next;
        frame <= 16'h0000;
        repeat (4) @(posedge mclk);
        chk(n_next - i, 1, "wait release");
        chk({24'h0, gp}, 32'h30, "wait flags");
        $display("test wait done");
        axi_wr(REG_FLAGS, 32'h55, RESP_OKAY);
        f = 8'h55;
        bad <= 1'b1;
        // flags left alone while each message runs
        for (i = 0; i < 32; i++) begin
            g = (i == 0) || (i == 10) || (i == 13);
            if (i >= 2 && i <= 9)
                g = f[i-2];
            ej = (i > 13);
            run_op(OP_EXEC, 16'h0040, 5'(i), 0, g, ej);
        end
        bad <= 1'b0;
        run_op(OP_EXEC, 16'h0040, 5'h1F, 0, 0, 0);
        chk({24'h0, gp}, 32'h55, "execute flags");
        axi_rd(REG_STATUS, 32'h8, RESP_OKAY);
        axi_wr(REG_STATUS, 32'h8, RESP_OKAY);
        axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
        $display("test execute done");
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
        chk({31'h0, iready}, 32'h0, "disabled");
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        chk({31'h0, iready}, 32'h1, "enabled");
        $display("test enable done");
        end_of_test();
    end
endmodule
